// ### psau_cfg.svh
`ifndef PSAU_CFG_SVH
`define PSAU_CFG_SVH
// Behaviour
// - Low-word table read/write reaches program bits 15..0, word or byte size.
// - High table read/write is the only data path to program bits 23..16.
// - Program addresses step by two per word; low and high spaces share addresses.
// - Low byte read picks upper byte when byte select is 1, else lower.
// - High word read returns bits 23..16 low, phantom byte reads zero.
// - Table address is table page concatenated with the 16-bit effective address.
// - Table page top bit selects user (0) or configuration (1) memory.
// - Data access maps to program memory when address bit 15 and enable set.
// - Mapping page supplies upper address bits, lower 15 address bits the rest.
// - Mapped reads return only the low 16 bits of the program word.
// - Mapped reads stretch the instruction, except in middle repeat iterations, because two fetches are needed.
// - Mapping is suspended while a table read or write is in progress.
// - Outside repeat: moves add one cycle, other instructions add two.
// - In repeat: first, last, interrupt exit and re-entry add two, others none.
// - Rows start on 192-byte, erase pages on 1536-byte boundaries.
// - Erase a page of eight rows; program one row or one word.
// - Holding buffers hold 64 instructions loaded from one aligned group.
// - Buffer-loading table writes finish in two instruction cycles.
// - Each row needs its own programming cycle after loading.
// - Setting write control starts the cycle, stalls core, clears at end.
`define PSAU_ROW_WORDS 64
`define PSAU_ROW_BYTES 192
`define PSAU_PAGE_BYTES 1536
`define PSAU_PAGE_ROWS 8
`define PSAU_TBL_WRITE_CYCLES 2
`define PSAU_OP_ROW 4'h1
`define PSAU_OP_WORD 4'h3
`define PSAU_OP_PAGE 4'h2
`define PSAU_ROW_TIME_CYCLES 64
`define PSAU_WORD_TIME_CYCLES 16
`define PSAU_ERASE_TIME_CYCLES 128
`endif

// ### psau_pkg.sv
package psau_pkg;
    typedef enum logic [1:0] {
        psau_idle_t_idle,
        psau_idle_t_busy
    } psau_flash_state_t;
    typedef enum logic [1:0] {
        psau_op_none,
        psau_op_read_low,
        psau_op_read_high,
        psau_op_write
    } psau_op_t;
endpackage

// ### psau_pm_model.sv
`timescale 1ns/1ps
// ====
// Program memory stand-in.
module psau_pm_model (
    // Request
    input wire logic mclk_in,
    input wire logic pm_read_in,
    input wire logic [23:0] pm_addr_in,
    // Answer
    output logic [23:0] pm_rdata_out
);
    initial pm_rdata_out = 24'h000000;
    // Outside the answer cycle the bus flips, so stale data never passes.
    // upper byte repeats address bit 1
    always @(posedge mclk_in) begin
        if (pm_read_in) begin
            pm_rdata_out <= {{8{pm_addr_in[1]}}, pm_addr_in[15:0] ^ 16'h5a3c};
        end else begin
            pm_rdata_out <= ~pm_rdata_out;
        end
    end
endmodule // psau_pm_model

// ### psau_top.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "psau_cfg.svh"
// Program space access unit: table reads/writes, data-space mapping, holding
// buffers and the self-timed erase/program sequencer, all on the core clock.
module psau_top import psau_pkg::*; #(
    parameter int ROW_TIME = `PSAU_ROW_TIME_CYCLES,
    parameter int WORD_TIME = `PSAU_WORD_TIME_CYCLES,
    parameter int ERASE_TIME = `PSAU_ERASE_TIME_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Table access from the core
    input wire logic table_read_low_word_in,
    input wire logic table_read_high_byte_in,
    input wire logic table_write_low_word_in,
    input wire logic table_write_high_byte_in,
    input wire logic byte_size_in,
    input wire logic [7:0] table_page_in,
    input wire logic [15:0] table_ea_in,
    input wire logic [15:0] table_wdata_in,
    // Data-space access from the core
    input wire logic data_read_in,
    input wire logic [15:0] data_ea_in,
    input wire logic program_mapping_enable_in,
    input wire logic [7:0] mapping_page_in,
    input wire logic move_insn_in,
    input wire logic in_repeat_in,
    input wire logic repeat_edge_iter_in,
    // Flash control
    input wire logic flash_start_in,
    input wire logic flash_erase_in,
    input wire logic [3:0] flash_op_in,
    // Program memory port
    output logic [23:0] pm_addr_out,
    output logic pm_config_space_out,
    output logic pm_read_out,
    input wire logic [23:0] pm_rdata_in,
    output logic pm_erase_out,
    output logic pm_program_out,
    output logic [23:0] pm_prog_addr_out,
    output logic [23:0] pm_prog_data_out,
    output logic [5:0] pm_prog_slot_out,
    // Results back to the core
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic [1:0] extra_cycles_out,
    output logic stall_out,
    output logic flash_busy_out
);
    // =====================================================
    // Address formation
    logic table_rd;
    logic table_wr;
    logic mapped;
    logic [23:0] table_addr;
    logic [23:0] map_addr;
    assign table_rd = table_read_low_word_in | table_read_high_byte_in;
    assign table_wr = table_write_low_word_in | table_write_high_byte_in;
    assign table_addr = {table_page_in, table_ea_in};
    assign mapped = data_read_in & data_ea_in[15] & program_mapping_enable_in
        & ~table_rd & ~table_wr;
    assign map_addr = {1'b0, mapping_page_in, data_ea_in[14:0]};

    always_comb begin
        pm_read_out = table_rd | mapped;
        pm_addr_out = mapped ? map_addr : table_addr;
        pm_config_space_out = ~mapped & table_page_in[7];
    end

    // =====================================================
    // Read data formatting, latched one cycle after the request
    logic rd_low_reg;
    logic rd_high_reg;
    logic rd_map_reg;
    logic byte_reg;
    logic bsel_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_low_reg <= 1'b0;
            rd_high_reg <= 1'b0;
            rd_map_reg <= 1'b0;
            byte_reg <= 1'b0;
            bsel_reg <= 1'b0;
        end else begin
            rd_low_reg <= table_read_low_word_in;
            rd_high_reg <= table_read_high_byte_in;
            rd_map_reg <= mapped;
            byte_reg <= byte_size_in;
            bsel_reg <= table_ea_in[0];
        end
    end

    logic [15:0] rdata_next;
    always_comb begin
        rdata_next = 16'h0000;
        if (rd_map_reg) begin
            rdata_next = pm_rdata_in[15:0];
        end else if (rd_low_reg) begin
            if (byte_reg) begin
                rdata_next = {8'h00, bsel_reg ? pm_rdata_in[15:8] : pm_rdata_in[7:0]};
            end else begin
                rdata_next = pm_rdata_in[15:0];
            end
        end else if (rd_high_reg) begin
            if (byte_reg && bsel_reg) begin
                rdata_next = 16'h0000;
            end else begin
                rdata_next = {8'h00, pm_rdata_in[23:16]};
            end
        end
    end

    logic [15:0] rdata_reg;
    logic rvalid_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rd_low_reg | rd_high_reg | rd_map_reg;
        end
    end
    assign rdata_out = rdata_reg;
    assign rvalid_out = rvalid_reg;

    // =====================================================
    // Mapped-access cycle penalty
    logic [1:0] extra_next;
    always_comb begin
        extra_next = 2'd0;
        if (mapped) begin
            if (in_repeat_in) begin
                extra_next = repeat_edge_iter_in ? 2'd2 : 2'd0;
            end else begin
                extra_next = move_insn_in ? 2'd1 : 2'd2;
            end
        end
    end
    logic [1:0] extra_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            extra_reg <= 2'd0;
        end else begin
            extra_reg <= extra_next;
        end
    end
    assign extra_cycles_out = extra_reg;

    // =====================================================
    // Holding buffers
    logic [23:0] hold_mem [`PSAU_ROW_WORDS];
    logic [23:0] row_base_reg;
    logic [5:0] slot;
    assign slot = table_ea_in[6:1];
    genvar gi;
    generate
        for (gi = 0; gi < `PSAU_ROW_WORDS; gi++) begin : g_hold
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    hold_mem[gi] <= 24'hffffff;
                end else if (table_wr && slot == 6'(gi)) begin
                    if (table_write_low_word_in) begin
                        if (!byte_size_in) begin
                            hold_mem[gi][15:0] <= table_wdata_in;
                        end else if (table_ea_in[0]) begin
                            hold_mem[gi][15:8] <= table_wdata_in[7:0];
                        end else begin
                            hold_mem[gi][7:0] <= table_wdata_in[7:0];
                        end
                    end else if (!(byte_size_in && table_ea_in[0])) begin
                        hold_mem[gi][23:16] <= table_wdata_in[7:0];
                    end
                end
            end
        end
    endgenerate

    logic wr_busy_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_busy_reg <= 1'b0;
            row_base_reg <= 24'h000000;
        end else begin
            wr_busy_reg <= table_wr;
            if (table_wr) begin
                row_base_reg <= table_addr;
            end
        end
    end

    // =====================================================
    // Flash sequencer
    // The legal start codes live in one place, so the decode and the timer agree on them.
    function automatic logic op_valid(input logic erase, input logic [3:0] op);
        logic ok;
        ok = erase ? (op == `PSAU_OP_PAGE) : (op == `PSAU_OP_ROW || op == `PSAU_OP_WORD);
        return ok;
    endfunction

    function automatic logic [15:0] op_time(input logic erase, input logic [3:0] op);
        logic [15:0] t;
        t = erase ? 16'(ERASE_TIME) : (op == `PSAU_OP_ROW ? 16'(ROW_TIME) : 16'(WORD_TIME));
        return t;
    endfunction

    psau_flash_state_t state_reg;
    logic [15:0] timer_reg;
    logic [5:0] prog_idx_reg;
    logic [3:0] op_reg;
    logic erase_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= psau_idle_t_idle;
            timer_reg <= 16'h0000;
            prog_idx_reg <= 6'h00;
            op_reg <= 4'h0;
            erase_reg <= 1'b0;
        end else begin
            case (state_reg)
                psau_idle_t_idle: begin
                    if (flash_start_in && op_valid(flash_erase_in, flash_op_in)) begin
                        state_reg <= psau_idle_t_busy;
                        op_reg <= flash_op_in;
                        erase_reg <= flash_erase_in;
                        prog_idx_reg <= 6'h00;
                        timer_reg <= op_time(flash_erase_in, flash_op_in);
                    end
                end
                psau_idle_t_busy: begin
                    prog_idx_reg <= prog_idx_reg + 6'h01;
                    if (timer_reg <= 16'h0001) begin
                        state_reg <= psau_idle_t_idle;
                    end
                    timer_reg <= timer_reg - 16'h0001;
                end
                default: state_reg <= psau_idle_t_idle;
            endcase
        end
    end

    logic busy;
    logic [23:0] row_start;
    logic [23:0] page_start;
    assign busy = (state_reg == psau_idle_t_busy);
    // aligned boundaries, counted in address units of two per word
    assign row_start = row_base_reg - (row_base_reg % 24'(2 * `PSAU_ROW_WORDS));
    assign page_start = row_base_reg
        - (row_base_reg % 24'(2 * `PSAU_ROW_WORDS * `PSAU_PAGE_ROWS));

    always_comb begin
        pm_erase_out = busy & erase_reg;
        pm_program_out = busy & ~erase_reg
            & (op_reg == `PSAU_OP_ROW || timer_reg == 16'(WORD_TIME));
        pm_prog_slot_out = (op_reg == `PSAU_OP_ROW) ? prog_idx_reg : row_base_reg[6:1];
        pm_prog_addr_out = erase_reg ? page_start
            : (op_reg == `PSAU_OP_ROW ? row_start + {17'h0, prog_idx_reg, 1'b0}
            : row_base_reg);
        pm_prog_data_out = hold_mem[pm_prog_slot_out];
    end

    assign flash_busy_out = busy;
    assign stall_out = busy | (table_wr & ~wr_busy_reg);
endmodule // psau_top

// ### psau_top_props.sv
`timescale 1ns/1ps
// ====
// Port checker.
module psau_top_props (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Requests
    input wire logic table_read_low_word_in,
    input wire logic table_read_high_byte_in,
    input wire logic table_write_low_word_in,
    input wire logic table_write_high_byte_in,
    input wire logic byte_size_in,
    input wire logic [7:0] table_page_in,
    input wire logic [15:0] table_ea_in,
    input wire logic data_read_in,
    input wire logic [15:0] data_ea_in,
    input wire logic program_mapping_enable_in,
    input wire logic [7:0] mapping_page_in,
    input wire logic move_insn_in,
    input wire logic in_repeat_in,
    input wire logic [23:0] pm_rdata_in,
    // Answers
    input wire logic [23:0] pm_addr_out,
    input wire logic pm_config_space_out,
    input wire logic pm_read_out,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic [1:0] extra_cycles_out,
    input wire logic stall_out,
    input wire logic flash_busy_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic any_tbl;
    logic any_rd;
    logic mapped;
    assign any_rd = table_read_low_word_in | table_read_high_byte_in;
    assign any_tbl = any_rd | table_write_low_word_in | table_write_high_byte_in;
    assign mapped = data_read_in & data_ea_in[15] & program_mapping_enable_in & ~any_tbl;
    sequence s_rd_low;
        table_read_low_word_in && !byte_size_in ##1 1'b1;
    endsequence
    sequence s_rd_high;
        table_read_high_byte_in && !byte_size_in ##1 1'b1;
    endsequence
    a_table_addr: assert property (any_rd |-> pm_addr_out == {table_page_in, table_ea_in})
        else $error("table address wrong");
    a_config_space: assert property (any_rd |-> pm_config_space_out == table_page_in[7])
        else $error("space select wrong");
    a_map_addr: assert property (mapped |-> pm_read_out
        && pm_addr_out == {1'b0, mapping_page_in, data_ea_in[14:0]}) else $error("mapped address");
    a_map_gate: assert property (data_read_in && !any_tbl
        && !(data_ea_in[15] && program_mapping_enable_in) |-> !pm_read_out) else $error("map gate");
    a_map_suspend: assert property (data_read_in && any_tbl |=> extra_cycles_out == 2'h0)
        else $error("mapping not suspended");
    a_low_word: assert property (s_rd_low |=> rvalid_out
        && rdata_out == $past(pm_rdata_in[15:0])) else $error("low word read");
    a_high_word: assert property (s_rd_high |=> rvalid_out
        && rdata_out == {8'h00, $past(pm_rdata_in[23:16])}) else $error("high word read");
    a_move_extra: assert property (mapped && move_insn_in && !in_repeat_in
        |=> extra_cycles_out == 2'h1) else $error("move extra cycle");
    a_write_stall: assert property ((table_write_low_word_in || table_write_high_byte_in)
        && !$past(table_write_low_word_in || table_write_high_byte_in) |-> stall_out)
        else $error("table write stall");
    a_busy_stall: assert property (flash_busy_out |-> stall_out)
        else $error("busy without stall");
endmodule // psau_top_props

bind psau_top psau_top_props u_props (.mclk_in(mclk_in), .rst_in(rst_in),
    .table_read_low_word_in(table_read_low_word_in), .byte_size_in(byte_size_in),
    .table_read_high_byte_in(table_read_high_byte_in), .table_page_in(table_page_in),
    .table_write_low_word_in(table_write_low_word_in), .table_ea_in(table_ea_in),
    .table_write_high_byte_in(table_write_high_byte_in), .data_read_in(data_read_in),
    .data_ea_in(data_ea_in), .program_mapping_enable_in(program_mapping_enable_in),
    .mapping_page_in(mapping_page_in), .move_insn_in(move_insn_in), .in_repeat_in(in_repeat_in),
    .pm_rdata_in(pm_rdata_in), .pm_addr_out(pm_addr_out), .pm_read_out(pm_read_out),
    .pm_config_space_out(pm_config_space_out), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .extra_cycles_out(extra_cycles_out), .stall_out(stall_out), .flash_busy_out(flash_busy_out));

// ### test_program_space_access_unit.sv
`timescale 1ns/1ps
// ====
// Self-checking bench.
module test_program_space_access_unit;
    logic mclk_in = 0, rst_in = 1, trl = 0, trh = 0, twl = 0, twh = 0, bsz = 0, drd = 0;
    logic men = 0, mov = 0, rpt = 0, edg = 0, fst = 0, fer = 0;
    logic [3:0] fop = 4'h0;
    logic [7:0] tpg = 8'h00, mpg = 8'h00;
    logic [15:0] tea = 16'h0000, twd = 16'h0000, dea = 16'h0000, rdo;
    logic [23:0] pma, ppd, prd, ppa;
    logic [5:0] slot;
    logic [1:0] xc;
    logic prr, ppg, rv, stl, bsy, pme;
    int mismatches = 0, check_count = 0;
    always #12.5 mclk_in = ~mclk_in;
    psau_top #(.WORD_TIME(4), .ERASE_TIME(8)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
        .table_read_low_word_in(trl), .table_read_high_byte_in(trh), .byte_size_in(bsz),
        .table_write_low_word_in(twl), .table_write_high_byte_in(twh), .table_page_in(tpg),
        .table_ea_in(tea), .table_wdata_in(twd), .data_read_in(drd), .data_ea_in(dea),
        .program_mapping_enable_in(men), .mapping_page_in(mpg), .move_insn_in(mov),
        .in_repeat_in(rpt), .repeat_edge_iter_in(edg), .flash_start_in(fst),
        .flash_erase_in(fer), .flash_op_in(fop), .pm_addr_out(pma), .pm_config_space_out(),
        .pm_read_out(prr), .pm_rdata_in(prd), .pm_erase_out(pme), .pm_program_out(ppg),
        .pm_prog_addr_out(ppa), .pm_prog_data_out(ppd), .pm_prog_slot_out(slot),
        .rdata_out(rdo), .rvalid_out(rv), .extra_cycles_out(xc), .stall_out(stl),
        .flash_busy_out(bsy));
    psau_pm_model pm (.mclk_in(mclk_in), .pm_read_in(prr), .pm_addr_in(pma), .pm_rdata_out(prd));
    function automatic logic [23:0] md(input logic [23:0] a);
        return {{8{a[1]}}, a[15:0] ^ 16'h5a3c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tbl_rd(input logic [7:0] pg, input logic hi, b, input logic [15:0] ea);
        logic [23:0] d;
        logic [15:0] e;
        d = md({pg, ea});
        e = hi ? ((b && ea[0]) ? 16'h0000 : {8'h00, d[23:16]}) : d[15:0];
        if (!hi && b) e = {8'h00, ea[0] ? d[15:8] : d[7:0]};
        @(posedge mclk_in);
        {trl, trh, bsz, tpg, tea} <= {!hi, hi, b, pg, ea};
        @(posedge mclk_in);
        {trl, trh} <= 2'b00;
        @(posedge mclk_in);
        #1 chk(rdo, e);
        chk(rv, 1'b1);
    endtask
    task automatic map_rd(input logic m, r, ed, en, t, input logic [1:0] e);
        logic [23:0] d;
        d = md({1'b0, 8'h13, 15'h0ac4});
        @(posedge mclk_in);
        {drd, dea, men, mov, rpt, edg, mpg, trl, tpg} <= {1'b1, 16'h8ac4, en, m, r, ed, 8'h13, t, 8'h00};
        @(posedge mclk_in);
        {drd, trl} <= 2'b00;
        #1 chk(xc, e);
        @(posedge mclk_in);
        #1 if (!t) chk({rv, rdo}, en ? {1'b1, d[15:0]} : 17'h00000);
    endtask
    task automatic flash_run(input logic e, input logic [3:0] op, input int n,
        input logic [23:0] a);
        @(posedge mclk_in);
        {fst, fer, fop} <= {1'b1, e, op};
        @(posedge mclk_in);
        fst <= 1'b0;
        for (int i = 0; i < n; i++) begin
            #1 chk(bsy, 1'b1);
            chk(pme, e);
            chk(ppa, (op == 4'h1) ? a + 24'(2 * i) : a);
            if (op == 4'h1) chk({ppg, slot, ppd}, {1'b1, i[5:0], i[7:0], 16'h1000 + i[15:0]});
            if (op == 4'h3) chk({ppg, slot, ppd}, {i == 0, 6'h3f, 8'h3f, 16'h103f});
            @(posedge mclk_in);
            fst <= (i == 9);
        end
        #1 chk(bsy, 1'b0);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) tbl_rd(i[2] ? 8'h81 : 8'h02, i[1], i[0], 16'h1236 + 16'(i[0] & i[2]));
        map_rd(1, 0, 0, 1, 0, 2'h1);
        map_rd(0, 0, 0, 1, 0, 2'h2);
        map_rd(0, 1, 1, 1, 0, 2'h2);
        map_rd(1, 1, 0, 1, 0, 2'h0);
        map_rd(0, 0, 0, 0, 0, 2'h0);
        map_rd(0, 0, 0, 1, 1, 2'h0);
        for (int i = 0; i < 64; i++) begin
            @(posedge mclk_in);
            {twl, bsz, tea, twd} <= {1'b1, 1'b0, 9'h0a5, i[5:0], 1'b0, 16'h1000 + i[15:0]};
            #1 chk(stl, 1'b1);
            @(posedge mclk_in);
            {twl, twh, twd} <= {1'b0, 1'b1, 8'h00, i[7:0]};
            @(posedge mclk_in);
            twh <= 1'b0;
        end
        flash_run(0, 4'h1, 64, 24'h005280);
        flash_run(1, 4'h2, 8, 24'h005000);
        flash_run(0, 4'h3, 4, 24'h0052fe);
        flash_run(0, 4'hf, 0, 24'h000000);
        end_of_test;
    end
endmodule // test_program_space_access_unit
